// >>> src/record_framer_regs.svh
`ifndef RECORD_FRAMER_REGS_SVH
`define RECORD_FRAMER_REGS_SVH

// ============================================================
// register byte addresses
`define REG_CTRL 12'h000
`define REG_PERIOD 12'h004
`define REG_USER_FIRST 12'h008
`define REG_USER_SECOND 12'h00C
`define REG_STATUS 12'h010
`define REG_LENGTH 12'h014

// ============================================================
// control fields and reset values
`define CTRL_SNAP_BIT 0
`define CTRL_PERIODIC_BIT 1
`define CTRL_VARIANT_LSB 2
`define CTRL_VARIANT_MSB 3
`define CTRL_ENC_BIT 4
`define CTRL_EXT_BIT 5
`define CTRL_RESET 5'h00
`define USER_RESET 32'h0000_0000

// ============================================================
// record layout, in 16-bit words
`define HDR_FIRST_WORD 16'h8000
`define CORE_WORDS 20
`define DIG_WORDS_BASIC 2
`define DIG_WORDS_WIDE 4
`define TAIL_WORDS 6
`define ENC_WORDS 8
`define EXT_WORDS 4
`define REC_MAX_WORDS 42

// ============================================================
// timing
`define CLK_MHZ 250
`define PERIOD_DEFAULT_US 1000
`define PERIOD_DEFAULT_CYC (`PERIOD_DEFAULT_US * `CLK_MHZ)

`endif

// >>> src/record_framer_pkg.sv
`default_nettype none

package record_framer_pkg;

    // ============================================================
    // digital section layouts
    typedef enum logic [1:0] {
        var_basic = 2'h0,
        var_out24 = 2'h1,
        var_io24 = 2'h2
    } variant_t;

    // ============================================================
    // sender states
    typedef enum logic [3:0] {
        s_idle = 4'h1,
        s_fetch = 4'h2,
        s_latch = 4'h4,
        s_send = 4'h8
    } framer_state_t;

    // ============================================================
    // live controller status, all on clk
    typedef struct packed {
        logic running;
        logic waiting;
        logic trace;
        logic echo;
        logic [7:0] error_code;
        logic [7:0][15:0] ao;
        logic [7:0][15:0] ai_raw;
        logic [7:0][2:0] ai_range;
        logic [47:0] dout;
        logic [47:0] din;
        logic [31:0] pulse;
        logic [3:0][31:0] enc;
    } io_snapshot_t;

    typedef struct packed {
        logic ext_fitted;
        logic enc_fitted;
        variant_t variant;
        logic periodic;
    } frame_cfg_t;

    typedef struct packed {
        logic last;
        logic periodic;
        logic [7:0] data;
    } byte_beat_t;

endpackage

`default_nettype wire

// >>> src/record_snapshot_mem.sv
`default_nettype none

module record_snapshot_mem #(
    parameter int WORDS = 42,
    parameter int WIDTH = 16,
    parameter int AW = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // whole-record write, one cycle
    input wire logic wr_en,
    input wire logic [WORDS*WIDTH-1:0] wr_vec,
    // registered read
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_q
);

    generate
        if (WORDS < 1 || WIDTH < 1 || (1 << AW) < WORDS) begin : g_bad
            $error("record_snapshot_mem: bad geometry");
        end
    endgenerate

    logic [WIDTH-1:0] mem_q [WORDS];

    // ============================================================
    // every word written in the same edge keeps the snapshot coherent
    always_ff @(posedge clk) begin
        if (wr_en) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_q[i] <= wr_vec[i*WIDTH +: WIDTH];
            end
        end
    end

    wire logic in_range = 32'(rd_addr) < WORDS;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= in_range ? mem_q[rd_addr] : '0;
        end
    end

endmodule

`default_nettype wire

// >>> src/io_status_record_framer.sv
`include "record_framer_regs.svh"
`default_nettype none

// Functional notes
// - one query yields exactly one record
// - periodic mode emits records without further requests
// - four header bytes, then whole body
// - first header word has bit 15 set
// - header bytes 2,3 carry total length
// - sample number, error code, status byte follow
// - status bits: running, waiting, trace, echo
// - eight analog outputs, then eight analog inputs
// - 24-output variant digital section layout
// - 24-bit variant: four digital words, pulse count
// - two signed user variables follow the pulse count, before any option words
// - encoder option appends four positions
// - extended option appends four digital words
// - analog input words sent low byte first
// - user fields hold software assigned values
// - bipolar ranges two's complement, unipolar unsigned
module io_status_record_framer #(
    parameter int PERIOD_RESET = `PERIOD_DEFAULT_CYC,
    parameter int COUNT_W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // live status from the controller
    input wire record_framer_pkg::io_snapshot_t live_status,
    // record byte stream
    output logic tx_valid,
    input wire logic tx_ready,
    output var record_framer_pkg::byte_beat_t tx_beat,
    output logic busy
);

    localparam int VEC_W = `REC_MAX_WORDS * 16;
    localparam int AW = 6;

    generate
        if (COUNT_W < 8 || COUNT_W > 32 || PERIOD_RESET < 1) begin : g_bad
            $error("io_status_record_framer: bad period settings");
        end
    endgenerate

    // ============================================================
    // record assembly
    function automatic logic [15:0] ai_count(input logic [15:0] raw, input logic [2:0] rng);
        // converter code is offset binary; bipolar ranges flip the sign bit
        if (rng == 3'h1 || rng == 3'h2) begin
            return {~raw[15], raw[14:0]};
        end
        return raw;
    endfunction

    function automatic int dig_words(input record_framer_pkg::variant_t v);
        return (v == record_framer_pkg::var_out24 || v == record_framer_pkg::var_io24) ?
            `DIG_WORDS_WIDE : `DIG_WORDS_BASIC;
    endfunction

    function automatic logic [7:0] rec_bytes(input record_framer_pkg::frame_cfg_t c);
        int w;
        w = `CORE_WORDS + dig_words(c.variant) + `TAIL_WORDS;
        if (c.enc_fitted) begin
            w = w + `ENC_WORDS;
        end
        if (c.ext_fitted) begin
            w = w + `EXT_WORDS;
        end
        return 8'(2 * w);
    endfunction

    function automatic logic [VEC_W-1:0] build_record(
        input record_framer_pkg::io_snapshot_t s,
        input record_framer_pkg::frame_cfg_t c,
        input logic [15:0] smp,
        input logic [31:0] u1,
        input logic [31:0] u2,
        input logic [7:0] nbytes
    );
        logic [VEC_W-1:0] v;
        logic [63:0] dig;
        logic [63:0] ext;
        logic [95:0] tail;
        logic [7:0][15:0] ai;
        logic [7:0] status;
        int off;
        status = {s.running, 4'h0, s.waiting, s.trace, s.echo};
        for (int i = 0; i < 8; i++) begin
            ai[i] = ai_count(s.ai_raw[i], s.ai_range[i]);
        end
        // word n sits at bits 16n, sent low byte first
        v = '0;
        v[319:0] = {ai, s.ao, status, s.error_code, smp, 8'h00, nbytes,
            `HDR_FIRST_WORD};
        case (c.variant)
            record_framer_pkg::var_out24: begin
                dig = {s.din[39:24], s.din[23:8], s.din[7:0], s.dout[23:16],
                    s.dout[15:0]};
            end
            record_framer_pkg::var_io24: begin
                dig = {8'h00, s.din[23:16], s.din[15:0], 8'h00, s.dout[23:16],
                    s.dout[15:0]};
            end
            default: begin
                dig = {32'h0000_0000, s.din[15:0], s.dout[15:0]};
            end
        endcase
        off = `CORE_WORDS;
        v = v | (VEC_W'(dig) << (off * 16));
        off = off + dig_words(c.variant);
        tail = {u2, u1, s.pulse};
        v = v | (VEC_W'(tail) << (off * 16));
        off = off + `TAIL_WORDS;
        if (c.enc_fitted) begin
            v = v | (VEC_W'(s.enc) << (off * 16));
            off = off + `ENC_WORDS;
        end
        ext = {8'h00, s.din[47:40], s.din[39:24], 8'h00, s.dout[47:40], s.dout[39:24]};
        if (c.ext_fitted) begin
            v = v | (VEC_W'(ext) << (off * 16));
        end
        return v;
    endfunction

    // ============================================================
    // registers
    logic [5:1] ctrl_q;
    logic [COUNT_W-1:0] period_q;
    logic [31:0] user1_q;
    logic [31:0] user2_q;
    logic [31:0] prdata_q;
    logic snap_pend_q;
    logic per_pend_q;
    logic [COUNT_W-1:0] per_cnt_q;
    logic [15:0] sample_q;
    logic [7:0] len_q;
    logic kind_q;
    logic [6:0] byte_q;
    logic [7:0] data_q;
    logic last_q;
    record_framer_pkg::framer_state_t state_q;
    record_framer_pkg::framer_state_t state_d;
    logic [15:0] rd_word;

    // ============================================================
    // apb decode
    wire logic acc = psel & penable;
    wire logic hit_ctrl = paddr == `REG_CTRL;
    wire logic hit_period = paddr == `REG_PERIOD;
    wire logic hit_user1 = paddr == `REG_USER_FIRST;
    wire logic hit_user2 = paddr == `REG_USER_SECOND;
    wire logic hit_status = paddr == `REG_STATUS;
    wire logic hit_length = paddr == `REG_LENGTH;
    wire logic hit_any = hit_ctrl | hit_period | hit_user1 | hit_user2 | hit_status | hit_length;
    wire logic wr = acc & pwrite & hit_any;
    wire logic [31:0] rd_mux =
        hit_ctrl ? {26'h0, ctrl_q, 1'h0} :
        hit_period ? 32'(period_q) :
        hit_user1 ? user1_q :
        hit_user2 ? user2_q :
        hit_status ? {sample_q, 13'h0, per_pend_q, snap_pend_q, busy} :
        hit_length ? {24'h0, len_q} : 32'h0000_0000;

    assign pready = 1'h1;
    assign pslverr = acc & ~hit_any;
    assign prdata = prdata_q;

    // ============================================================
    // request scheduling
    wire record_framer_pkg::frame_cfg_t cfg = {ctrl_q[`CTRL_EXT_BIT], ctrl_q[`CTRL_ENC_BIT],
        record_framer_pkg::variant_t'(ctrl_q[`CTRL_VARIANT_MSB:`CTRL_VARIANT_LSB]),
        ctrl_q[`CTRL_PERIODIC_BIT]};
    wire logic [COUNT_W-1:0] per_top = (period_q == '0) ? '0 : period_q - 1'b1;
    wire logic tick = cfg.periodic & (per_cnt_q >= per_top);
    wire logic start = (state_q == record_framer_pkg::s_idle) & (snap_pend_q | per_pend_q);
    wire logic snap_set = wr & hit_ctrl & pwdata[`CTRL_SNAP_BIT];
    // a new request in the serving cycle survives: set wins over clear
    wire logic snap_pend_d = snap_set | (snap_pend_q & ~start);
    wire logic per_pend_d = cfg.periodic &
        (tick | (per_pend_q & ~(start & ~snap_pend_q)));
    wire logic [7:0] rec_len = rec_bytes(cfg);
    wire logic [VEC_W-1:0] rec_vec = build_record(live_status, cfg, sample_q, user1_q,
        user2_q, rec_len);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CTRL_RESET;
            period_q <= COUNT_W'(PERIOD_RESET);
            user1_q <= `USER_RESET;
            user2_q <= `USER_RESET;
            prdata_q <= 32'h0000_0000;
        end else begin
            if (wr & hit_ctrl) begin
                ctrl_q <= pwdata[5:1];
            end
            if (wr & hit_period) begin
                period_q <= pwdata[COUNT_W-1:0];
            end
            if (wr & hit_user1) begin
                user1_q <= pwdata;
            end
            if (wr & hit_user2) begin
                user2_q <= pwdata;
            end
            if (psel & ~penable) begin
                prdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            snap_pend_q <= 1'h0;
            per_pend_q <= 1'h0;
            per_cnt_q <= '0;
        end else begin
            snap_pend_q <= snap_pend_d;
            per_pend_q <= per_pend_d;
            per_cnt_q <= (~cfg.periodic | tick) ? '0 : per_cnt_q + 1'b1;
        end
    end

    // ============================================================
    // capture: whole record written in one edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_q <= 16'h0000;
            len_q <= 8'h00;
            kind_q <= 1'h0;
        end else if (start) begin
            sample_q <= sample_q + 16'h0001;
            len_q <= rec_len;
            kind_q <= ~snap_pend_q;
        end
    end

    record_snapshot_mem #(
        .WORDS(`REC_MAX_WORDS),
        .WIDTH(16),
        .AW(AW)
    ) u_mem (
        .clk(clk),
        .rst(rst),
        .wr_en(start),
        .wr_vec(rec_vec),
        .rd_addr(byte_q[6:1]),
        .rd_data_q(rd_word)
    );

    // ============================================================
    // sender: three cycles a byte, trading rate for a flopped data path
    wire logic at_last = {1'h0, byte_q} == (len_q - 8'h01);

    always_comb begin
        state_d = state_q;
        case (state_q)
            record_framer_pkg::s_idle: begin
                if (start) begin
                    state_d = record_framer_pkg::s_fetch;
                end
            end
            record_framer_pkg::s_fetch: begin
                state_d = record_framer_pkg::s_latch;
            end
            record_framer_pkg::s_latch: begin
                state_d = record_framer_pkg::s_send;
            end
            record_framer_pkg::s_send: begin
                if (tx_ready) begin
                    state_d = last_q ? record_framer_pkg::s_idle : record_framer_pkg::s_fetch;
                end
            end
            default: begin
                state_d = record_framer_pkg::s_idle;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= record_framer_pkg::s_idle;
            byte_q <= 7'h00;
            data_q <= 8'h00;
            last_q <= 1'h0;
        end else begin
            state_q <= state_d;
            if (start) begin
                byte_q <= 7'h00;
            end else if (state_q == record_framer_pkg::s_send && tx_ready && !last_q) begin
                byte_q <= byte_q + 7'h01;
            end
            if (state_q == record_framer_pkg::s_latch) begin
                data_q <= byte_q[0] ? rd_word[15:8] : rd_word[7:0];
                last_q <= at_last;
            end
        end
    end

    assign tx_valid = state_q == record_framer_pkg::s_send;
    assign tx_beat = {last_q, kind_q, data_q};
    assign busy = state_q != record_framer_pkg::s_idle;

endmodule

`default_nettype wire

// >>> testbench/record_checker.sv
`include "record_framer_regs.svh"
`default_nettype none

module record_checker #(
    parameter int PERIOD_RESET = `PERIOD_DEFAULT_CYC,
    parameter int COUNT_W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb requests
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // record stream
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire record_framer_pkg::byte_beat_t tx_beat,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ==========
    // byte position and header fields of the record on the wire
    logic [6:0] pos_q;
    logic seen_q;
    logic per_q;
    logic [15:0] len_q;
    logic [7:0] smp_lo_q;
    logic [15:0] smp_q;
    wire logic acc = tx_valid && tx_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos_q <= 7'h00;
            seen_q <= 1'b0;
        end else if (acc) begin
            pos_q <= tx_beat.last ? 7'h00 : pos_q + 7'h01;
            seen_q <= seen_q | (pos_q == 7'h05);
        end
    end

    // data only; meaningless until the matching position has passed
    always_ff @(posedge clk) begin
        if (acc && pos_q == 7'h00) per_q <= tx_beat.periodic;
        if (acc && pos_q == 7'h02) len_q[7:0] <= tx_beat.data;
        if (acc && pos_q == 7'h03) len_q[15:8] <= tx_beat.data;
        if (acc && pos_q == 7'h04) smp_lo_q <= tx_beat.data;
        if (acc && pos_q == 7'h05) smp_q <= {tx_beat.data, smp_lo_q};
    end

    // ==========
    // properties
    sequence stalled_s;
        tx_valid && !tx_ready;
    endsequence
    sequence end_rec_s;
        acc && tx_beat.last;
    endsequence

    beat_hold_a: assert property (stalled_s |=> tx_valid && $stable(tx_beat))
        else $error("beat changed while stalled");
    rec_gap_a: assert property (end_rec_s |=> !tx_valid)
        else $error("no idle cycle after record");
    valid_busy_a: assert property (tx_valid |-> busy)
        else $error("valid without busy");
    hdr_low_a: assert property (tx_valid && pos_q == 7'h00 |-> tx_beat.data == 8'h00)
        else $error("header byte 0 wrong");
    hdr_mark_a: assert property (tx_valid && pos_q == 7'h01 |-> tx_beat.data == 8'h80)
        else $error("header bit 15 not set");
    len_match_a: assert property (end_rec_s |-> len_q == {9'h000, pos_q} + 16'h0001)
        else $error("length field differs from bytes sent");
    len_set_a: assert property (end_rec_s |-> len_q inside {16'h0038, 16'h003C,
        16'h0040, 16'h0044, 16'h0048, 16'h004C, 16'h0050, 16'h0054})
        else $error("record length not a legal layout");
    per_same_a: assert property (tx_valid && pos_q != 7'h00 |-> tx_beat.periodic == per_q)
        else $error("periodic flag changed inside record");
    smp_step_a: assert property (acc && pos_q == 7'h05 && seen_q
        |-> {tx_beat.data, smp_lo_q} == smp_q + 16'h0001)
        else $error("sample number did not advance by one");
    snap_start_a: assert property (psel && penable && pwrite && paddr == `REG_CTRL
        && pwdata[`CTRL_SNAP_BIT] && !busy |-> ##[2:6] tx_valid)
        else $error("snapshot request not answered");
endmodule

`default_nettype wire

// >>> testbench/record_sink.sv
`default_nettype none

module record_sink (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // record stream
    input wire logic tx_valid,
    output logic tx_ready,
    input wire record_framer_pkg::byte_beat_t tx_beat,
    // bench control
    input wire logic stall_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] rx_q[$];
    logic [1:0] ph_q;

    // ==========
    // host side: drops ready one cycle in four when stalling, to load the hold path
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_q <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            ph_q <= ph_q + 2'h1;
            tx_ready <= !(stall_en && ph_q == 2'h3);
            if (tx_valid && tx_ready) begin
                rx_q.push_back({tx_beat.periodic, tx_beat.last, tx_beat.data});
            end
        end
    end
endmodule

`default_nettype wire

// >>> testbench/tb.sv
`include "record_framer_regs.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [7:0] bq_t[$];
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tx_valid;
    logic tx_ready;
    logic busy;
    logic stall_en = 1'b0;
    record_framer_pkg::io_snapshot_t ls;
    record_framer_pkg::byte_beat_t tx_beat;
    int failures = 0;
    int n_tests = 0;
    logic [15:0] smp = 16'h0000;
    logic [31:0] rd;
    logic err;
    bq_t exp_q;

    always #2 clk = ~clk;

    io_status_record_framer #(.PERIOD_RESET(20), .COUNT_W(32)) i_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .live_status(ls), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_beat(tx_beat), .busy(busy));
    record_sink i_sink (.clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_beat(tx_beat), .stall_en(stall_en));

    // ==========
    // shared tasks
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (!ok) begin
            failures++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic set_ls(input logic [7:0] k);
        record_framer_pkg::io_snapshot_t v;
        v.running = k[0];
        v.waiting = 1'b1;
        v.trace = k[1];
        v.echo = 1'b1;
        v.error_code = 8'h5A ^ k;
        for (int i = 0; i < 8; i++) begin
            v.ao[i] = {k, 8'(i)} ^ 16'hC300;
            v.ai_raw[i] = 16'h7F80 ^ {8'(i), k};
            v.ai_range[i] = 3'(i % 5);
        end
        v.dout = {6{k ^ 8'hA5}} ^ 48'h0123_4567_89AB;
        v.din = {6{k}} ^ 48'hFEDC_BA98_7654;
        v.pulse = {4{k}} ^ 32'h8765_4321;
        for (int j = 0; j < 4; j++) v.enc[j] = {k, 24'hF0_0001} + 32'(j);
        ls <= v;
    endtask

    task automatic pw(input logic [15:0] w);
        exp_q.push_back(w[7:0]);
        exp_q.push_back(w[15:8]);
    endtask

    task automatic pl(input logic [31:0] w);
        pw(w[15:0]);
        pw(w[31:16]);
    endtask

    // expected record image; c follows the control layout
    task automatic build(input logic [5:0] c);
        logic [15:0] a;
        logic [47:0] o;
        logic [47:0] n;
        o = ls.dout;
        n = ls.din;
        exp_q = {};
        pw(smp);
        pw({ls.running, 4'h0, ls.waiting, ls.trace, ls.echo, ls.error_code});
        for (int i = 0; i < 8; i++) pw(ls.ao[i]);
        for (int i = 0; i < 8; i++) begin
            a = ls.ai_raw[i];
            // converter code is offset binary, so bipolar ranges flip the sign bit
            if (ls.ai_range[i] inside {3'h1, 3'h2}) a[15] = ~a[15];
            pw(a);
        end
        if (c[3:2] == 2'h1) begin
            pw(o[15:0]);
            pw({n[7:0], o[23:16]});
            pw(n[23:8]);
            pw(n[39:24]);
        end else if (c[3:2] == 2'h2) begin
            pw(o[15:0]);
            pw({8'h00, o[23:16]});
            pw(n[15:0]);
            pw({8'h00, n[23:16]});
        end else begin
            pw(o[15:0]);
            pw(n[15:0]);
        end
        pl(ls.pulse);
        pl(32'h8000_00F1);
        pl(32'h7E5D_C0A2);
        if (c[4]) for (int j = 0; j < 4; j++) pl(ls.enc[j]);
        if (c[5]) begin
            pw(o[39:24]);
            pw({8'h00, o[47:40]});
            pw(n[39:24]);
            pw({8'h00, n[47:40]});
        end
        a = 16'(exp_q.size() + 4);
        exp_q.push_front(a[15:8]);
        exp_q.push_front(a[7:0]);
        exp_q.push_front(8'h80);
        exp_q.push_front(8'h00);
    endtask

    task automatic get_rec(input logic per);
        logic [9:0] b;
        for (int t = 0; t < 3000 && i_sink.rx_q.size() < exp_q.size(); t++) @(posedge clk);
        chk(i_sink.rx_q.size() >= exp_q.size(), "record missing");
        foreach (exp_q[i]) begin
            b = i_sink.rx_q.pop_front();
            chk(b[7:0] === exp_q[i], "record byte");
            chk(b[9:8] === {per, 1'(i == exp_q.size() - 1)}, "beat flags");
        end
        smp = smp + 16'h0001;
    endtask

    // ==========
    // scenarios
    task automatic t_regs;
        logic [11:0] a[5] = '{`REG_CTRL, `REG_PERIOD, `REG_USER_FIRST, `REG_USER_SECOND,
            `REG_STATUS};
        logic [31:0] e[5] = '{32'h0, 32'h14, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, a[i], 32'h0);
            chk(rd === e[i] && err === 1'b0, "reset value");
        end
        apb(1'b1, 12'h018, 32'hFFFF_FFFF);
        chk(err === 1'b1, "unmapped write");
        apb(1'b0, 12'h018, 32'h0);
        chk(err === 1'b1 && rd === 32'h0, "unmapped read");
        apb(1'b1, `REG_USER_FIRST, 32'h8000_00F1);
        apb(1'b1, `REG_USER_SECOND, 32'h7E5D_C0A2);
        apb(1'b0, `REG_USER_SECOND, 32'h0);
        chk(rd === 32'h7E5D_C0A2, "user readback");
    endtask

    // one-shot with a stalling host; live data moves while the record is in flight
    task automatic t_snap;
        stall_en <= 1'b1;
        build(6'h01);
        apb(1'b1, `REG_CTRL, 32'h1);
        for (int t = 0; t < 20 && busy !== 1'b1; t++) @(posedge clk);
        set_ls(8'h3C);
        get_rec(1'b0);
        repeat (100) @(posedge clk);
        chk(i_sink.rx_q.size() == 0 && busy === 1'b0, "extra record");
        apb(1'b0, `REG_LENGTH, 32'h0);
        chk(rd === 32'h38, "basic length");
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(rd === {smp, 16'h0000}, "next sample number");
        stall_en <= 1'b0;
    endtask

    task automatic t_var;
        logic [5:0] c[3] = '{6'h15, 6'h29, 6'h3D};
        logic [31:0] l[3] = '{32'h4C, 32'h44, 32'h50};
        for (int i = 0; i < 3; i++) begin
            build(c[i]);
            apb(1'b1, `REG_CTRL, {26'h0, c[i]});
            get_rec(1'b0);
            apb(1'b0, `REG_LENGTH, 32'h0);
            chk(rd === l[i], "option length");
        end
    endtask

    task automatic t_per;
        apb(1'b1, `REG_PERIOD, 32'h1E);
        apb(1'b0, `REG_PERIOD, 32'h0);
        chk(rd === 32'h1E, "period readback");
        stall_en <= 1'b1;
        apb(1'b1, `REG_CTRL, 32'h2);
        for (int i = 0; i < 2; i++) begin
            build(6'h00);
            get_rec(1'b1);
        end
        apb(1'b1, `REG_CTRL, 32'h0);
    endtask

    task automatic end_sim;
        if (failures == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        set_ls(8'h00);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_snap();
        t_var();
        t_per();
        end_sim();
    end

    // about seven times the expected run
    initial begin
        #40000;
        failures++;
        end_sim();
    end
endmodule

bind io_status_record_framer record_checker #(.PERIOD_RESET(PERIOD_RESET),
    .COUNT_W(COUNT_W)) i_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_beat(tx_beat), .busy(busy));

`default_nettype wire
